// >>> ams_map.vh
// Register offsets, field positions, command codes and reset values of the converter.
`ifndef AMS_MAP_VH
`define AMS_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets (five-bit register address space)
// ----------------------------------------------------------------------------
`define AMS_REG_RATE        5'h02
`define AMS_REG_DELAY       5'h03
`define AMS_REG_PIN_DIR     5'h04
`define AMS_REG_PIN_LEVEL   5'h05
`define AMS_REG_GAIN        5'h10

// ----------------------------------------------------------------------------
// Command bytes and frame layout
// ----------------------------------------------------------------------------
`define AMS_CMD_RESET       8'h06
`define AMS_CMD_START       8'h08
`define AMS_CMD_READ        8'h12
`define AMS_CMD_REGISTER_WRITE_CMD_TOP    3'h2
`define AMS_CMD_RREG_TOP    3'h1
`define AMS_FILL_BYTE       8'hff
`define AMS_IDX_LAST_CMD    4'h3
`define AMS_IDX_STATUS      4'h4
`define AMS_IDX_MSB         4'h5
`define AMS_IDX_MID         4'h6
`define AMS_IDX_LSB         4'h7
`define AMS_IDX_CHECK       4'h8
`define AMS_IDX_MAX         4'hf
`define AMS_BIT_LAST        3'h7
`define AMS_CHECK_SEED      8'h9b

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define AMS_RATE_BITS       4:0
`define AMS_FILT_BITS       7:5
`define AMS_CON_BITS        3:0
`define AMS_DIR_BITS        7:4
`define AMS_LVL_BITS        3:0
`define AMS_GAIN_BITS       3:0
`define AMS_ROUTE_BITS      6:4
`define AMS_RST_RATE        5'h04
`define AMS_RST_FILT        3'h0
`define AMS_RST_GAIN        4'h0
`define AMS_RST_NIB         4'h0
`define AMS_SYNC_RST        7'h02
`define AMS_FIFO_DEPTH      2'h2

`endif

// >>> ams_regmem.v
// Register memory of the converter with a registered read port.
module ams_regmem (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       we,
	input  wire [4:0] waddr,
	input  wire [7:0] wdata,
	input  wire [4:0] raddr,
	output reg  [7:0] rdata_r
);
	reg [7:0] mem [0:31];

	// ------------------------------------------------------------------------
	// Storage and read port
	// ------------------------------------------------------------------------
	// Contents are not cleared by reset; the live copies in the top hold defaults.
	always @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// The read word is held in a flop so readback never sees a half-written cell.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= mem[raddr];
		end
	end
endmodule

// >>> ams_converter.v
// Serial control, pin logic and result path of the converter with multiplexer steering pins.
`include "ams_map.vh"
module ams_converter (
	input  wire        clk,
	input  wire        resetn,
	input  wire        sclk,
	input  wire        cs_n,
	input  wire        mosi,
	output reg         miso_r,
	output reg         miso_oe_n_r,
	output reg         result_ready_n_r,
	input  wire [3:0]  gpio_in,
	output reg  [3:0]  gpio_out_r,
	output reg  [3:0]  gpio_oe_n_r,
	input  wire        sample_valid,
	input  wire [23:0] sample_data,
	output reg         sample_ready_r,
	output reg  [4:0]  rate_field_r,
	output reg  [2:0]  filter_field_r,
	output reg  [3:0]  gain_field_r,
	output reg  [2:0]  input_route_field_r
);
	// ------------------------------------------------------------------------
	// Reset release and input synchronisers
	// ------------------------------------------------------------------------
	reg        rst_a_r;
	reg        rst_n;
	wire [6:0] raw = {gpio_in, mosi, cs_n, sclk};
	reg  [6:0] s1_r;
	reg  [6:0] s2_r;
	reg  [6:0] s3_r;
	reg  [6:0] stab_r;
	wire [6:0] chg;

	// Reset is asserted at once and released two edges later.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_a_r <= 1'b0;
			rst_n   <= 1'b0;
		end else begin
			rst_a_r <= 1'b1;
			rst_n   <= rst_a_r;
		end
	end

	// Idle levels of the pins after reset, one bit per synchroniser.
	localparam [6:0] SYNC_INIT = `AMS_SYNC_RST;

	// Three flops per pin; a level counts once the second and third agree.
	genvar g;
	generate
		for (g = 0; g < 7; g = g + 1) begin : g_sync
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					s1_r[g]   <= SYNC_INIT[g];
					s2_r[g]   <= SYNC_INIT[g];
					s3_r[g]   <= SYNC_INIT[g];
					stab_r[g] <= SYNC_INIT[g];
				end else begin
					s1_r[g] <= raw[g];
					s2_r[g] <= s1_r[g];
					s3_r[g] <= s2_r[g];
					if (chg[g]) begin
						stab_r[g] <= s3_r[g];
					end
				end
			end
			assign chg[g] = (s2_r[g] == s3_r[g]) && (s3_r[g] != stab_r[g]);
		end
	endgenerate

	wire sel    = ~stab_r[1];
	wire sel_on = chg[1] & ~s3_r[1];
	wire sel_off = chg[1] & s3_r[1];
	wire rise   = sel & chg[0] & s3_r[0];
	wire fall   = sel & chg[0] & ~s3_r[0];
	wire din    = s3_r[2];

	// ------------------------------------------------------------------------
	// Two-entry result buffer
	// ------------------------------------------------------------------------
	reg [23:0] fifo_r [0:1];
	reg        wp_r;
	reg        rp_r;
	reg  [1:0] cnt_r;
	reg  [1:0] cnt_nxt;
	reg        running_r;
	reg [23:0] res_r;
	reg        res_full_r;
	reg [23:0] snap_r;
	wire       push = sample_valid & sample_ready_r;
	wire       pop  = (cnt_r != 2'h0) & ~res_full_r;

	always @* begin
		cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
	end

	// Ready is registered from the next fill level, so a push always finds room.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r           <= 1'b0;
			rp_r           <= 1'b0;
			cnt_r          <= 2'h0;
			sample_ready_r <= 1'b0;
		end else begin
			cnt_r          <= cnt_nxt;
			sample_ready_r <= running_r && (cnt_nxt < `AMS_FIFO_DEPTH);
			if (push) begin
				wp_r <= ~wp_r;
			end
			if (pop) begin
				rp_r <= ~rp_r;
			end
		end
	end

	// Buffer words need no reset; they are only read after a push has filled them.
	always @(posedge clk) begin
		if (push) begin
			fifo_r[wp_r] <= sample_data;
		end
	end

	// ------------------------------------------------------------------------
	// Serial slave, mode 1: shift out on rising, sample on falling
	// ------------------------------------------------------------------------
	reg  [2:0] bit_r;
	reg  [3:0] byte_r;
	reg  [7:0] rx_r;
	reg  [7:0] tx_r;
	reg  [7:0] cmd_r;
	reg  [7:0] arg_r;
	reg  [7:0] tx_nxt;
	reg  [3:0] con_r;
	reg  [3:0] dir_r;
	reg  [3:0] lvl_r;
	reg  [7:0] stat_r;
	wire [7:0] rxb      = {rx_r[6:0], din};
	wire       byte_end = fall && (bit_r == `AMS_BIT_LAST);
	wire [3:0] idx_nxt  = (byte_r == `AMS_IDX_MAX) ? byte_r : byte_r + 4'h1;
	wire [7:0] rdata;
	wire [7:0] status   = {stab_r[6:3] & con_r & dir_r, 2'h0, running_r, res_full_r};
	// The check covers the status byte as sent, not the live one, which may move meanwhile.
	wire [7:0] check    = stat_r ^ snap_r[23:16] ^ snap_r[15:8] ^ snap_r[7:0] ^ `AMS_CHECK_SEED;
	wire       is_register_write_cmd  = (cmd_r[7:5] == `AMS_CMD_REGISTER_WRITE_CMD_TOP);
	wire       cmd_done = byte_end && (byte_r == `AMS_IDX_LAST_CMD);

	// Next byte to send: echo of the first three command bytes, then the read payload.
	always @* begin
		tx_nxt = 8'h00;
		if (idx_nxt <= `AMS_IDX_LAST_CMD) begin
			tx_nxt = rxb;
		end else if (cmd_r == `AMS_CMD_READ) begin
			case (idx_nxt)
				`AMS_IDX_STATUS: tx_nxt = status;
				`AMS_IDX_MSB:    tx_nxt = snap_r[23:16];
				`AMS_IDX_MID:    tx_nxt = snap_r[15:8];
				`AMS_IDX_LSB:    tx_nxt = snap_r[7:0];
				`AMS_IDX_CHECK:  tx_nxt = check;
				default:         tx_nxt = 8'h00;
			endcase
		end else if (cmd_r[7:5] == `AMS_CMD_RREG_TOP && idx_nxt == `AMS_IDX_STATUS) begin
			tx_nxt = rdata;
		end
	end

	// Bit engine; the first byte out is always the fill byte.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_r       <= 3'h0;
			byte_r      <= 4'h0;
			rx_r        <= 8'h00;
			tx_r        <= 8'h00;
			cmd_r       <= 8'h00;
			arg_r       <= 8'h00;
			stat_r      <= 8'h00;
			miso_r      <= 1'b0;
			miso_oe_n_r <= 1'b1;
		end else if (sel_on) begin
			bit_r       <= 3'h0;
			byte_r      <= 4'h0;
			tx_r        <= `AMS_FILL_BYTE;
			miso_oe_n_r <= 1'b0;
		end else if (sel_off) begin
			miso_oe_n_r <= 1'b1;
		end else if (rise) begin
			miso_r <= tx_r[7];
			tx_r   <= {tx_r[6:0], 1'b0};
		end else if (fall) begin
			rx_r  <= rxb;
			bit_r <= bit_r + 3'h1;
			if (byte_end) begin
				byte_r <= idx_nxt;
				tx_r   <= tx_nxt;
				if (idx_nxt == `AMS_IDX_STATUS) begin
					stat_r <= status;
				end
				if (byte_r == 4'h0) begin
					cmd_r <= rxb;
				end
				if (byte_r == 4'h1) begin
					arg_r <= rxb;
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// Commands, live registers and steering pins
	// ------------------------------------------------------------------------
	wire read_go = byte_end && (byte_r == 4'h0) && (rxb == `AMS_CMD_READ);
	wire wr_go   = cmd_done && is_register_write_cmd;

	ams_regmem u_mem (
		.clk     (clk),
		.rst_n   (rst_n),
		.we      (wr_go),
		.waddr   (cmd_r[4:0]),
		.wdata   (arg_r),
		.raddr   (cmd_r[4:0]),
		.rdata_r (rdata)
	);

	// A frame's writes and reset/start commands act once all four command bytes are in; a read acts after its first byte.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			running_r           <= 1'b0;
			rate_field_r        <= `AMS_RST_RATE;
			filter_field_r      <= `AMS_RST_FILT;
			gain_field_r        <= `AMS_RST_GAIN;
			input_route_field_r <= 3'h0;
			con_r               <= `AMS_RST_NIB;
			dir_r               <= `AMS_RST_NIB;
			lvl_r               <= `AMS_RST_NIB;
		end else if (cmd_done && cmd_r == `AMS_CMD_RESET) begin
			running_r           <= 1'b0;
			rate_field_r        <= `AMS_RST_RATE;
			filter_field_r      <= `AMS_RST_FILT;
			gain_field_r        <= `AMS_RST_GAIN;
			input_route_field_r <= 3'h0;
			con_r               <= `AMS_RST_NIB;
			dir_r               <= `AMS_RST_NIB;
			lvl_r               <= `AMS_RST_NIB;
		end else if (cmd_done && cmd_r == `AMS_CMD_START) begin
			running_r <= 1'b1;
		end else if (wr_go) begin
			case (cmd_r[4:0])
				`AMS_REG_RATE: begin
					rate_field_r   <= arg_r[`AMS_RATE_BITS];
					filter_field_r <= arg_r[`AMS_FILT_BITS];
				end
				`AMS_REG_PIN_DIR: begin
					con_r <= arg_r[`AMS_CON_BITS];
					dir_r <= arg_r[`AMS_DIR_BITS];
				end
				`AMS_REG_PIN_LEVEL: lvl_r <= arg_r[`AMS_LVL_BITS];
				`AMS_REG_GAIN: begin
					gain_field_r        <= arg_r[`AMS_GAIN_BITS];
					input_route_field_r <= arg_r[`AMS_ROUTE_BITS];
				end
				default: ;
			endcase
		end
	end

	// A pin drives only when connected and set as output; others float.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gpio_out_r  <= 4'h0;
			gpio_oe_n_r <= 4'hf;
		end else begin
			gpio_out_r  <= lvl_r;
			gpio_oe_n_r <= ~(con_r & ~dir_r);
		end
	end

	// ------------------------------------------------------------------------
	// Result holding and ready line
	// ------------------------------------------------------------------------
	// A result waits until read, so slow reads stall the buffer rather than drop.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			res_r            <= 24'h000000;
			res_full_r       <= 1'b0;
			snap_r           <= 24'h000000;
			result_ready_n_r <= 1'b1;
		end else if (pop) begin
			res_r            <= fifo_r[rp_r];
			res_full_r       <= 1'b1;
			result_ready_n_r <= 1'b0;
		end else if (read_go) begin
			snap_r           <= res_r;
			res_full_r       <= 1'b0;
			result_ready_n_r <= 1'b1;
		end
	end
endmodule

// >>> ams_converter_props.sv
// Concurrent checks on the converter ports.
module ams_converter_props (
	input logic        clk,
	input logic        resetn,
	input logic        sclk,
	input logic        cs_n,
	input logic        mosi,
	input logic        miso_r,
	input logic        miso_oe_n_r,
	input logic        result_ready_n_r,
	input logic [3:0]  gpio_in,
	input logic [3:0]  gpio_out_r,
	input logic [3:0]  gpio_oe_n_r,
	input logic        sample_valid,
	input logic [23:0] sample_data,
	input logic        sample_ready_r,
	input logic [4:0]  rate_field_r,
	input logic [2:0]  filter_field_r,
	input logic [3:0]  gain_field_r,
	input logic [2:0]  input_route_field_r
);
	// ----------------------------------------
	// Link, result and pin properties
	// ----------------------------------------
	// Eight idle samples cover the three-flop select path plus the output register.
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_miso_idle_float: assert property (cs_n [*8] |-> miso_oe_n_r)
		else $error("miso driven while deselected");
	a_miso_sel_drive: assert property (!cs_n [*8] |-> !miso_oe_n_r)
		else $error("miso not driven while selected");
	a_fill_leads: assert property ($fell(miso_oe_n_r) |-> ##[0:12] miso_r)
		else $error("first byte not all ones");
	a_ready_holds_idle: assert property (!result_ready_n_r && cs_n |=> !result_ready_n_r)
		else $error("ready dropped without a read");
	a_ready_after_push: assert property (sample_valid && sample_ready_r && result_ready_n_r && cs_n
		|-> ##[1:4] !result_ready_n_r)
		else $error("accepted sample not signalled");
	a_buffer_full_stall: assert property ((sample_valid && sample_ready_r && !result_ready_n_r && cs_n) [*2]
		|=> !sample_ready_r)
		else $error("buffer accepts beyond two entries");
	a_pins_hold_idle: assert property (cs_n [*8] |-> $stable(gpio_out_r) && $stable(gpio_oe_n_r))
		else $error("pins moved without a frame");
	a_fields_hold_idle: assert property (cs_n [*8]
		|-> $stable({rate_field_r, filter_field_r, gain_field_r, input_route_field_r}))
		else $error("fields moved without a frame");
endmodule

bind ams_converter ams_converter_props u_props (.clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
	.mosi(mosi), .miso_r(miso_r), .miso_oe_n_r(miso_oe_n_r), .result_ready_n_r(result_ready_n_r),
	.gpio_in(gpio_in), .gpio_out_r(gpio_out_r), .gpio_oe_n_r(gpio_oe_n_r), .sample_valid(sample_valid),
	.sample_data(sample_data), .sample_ready_r(sample_ready_r), .rate_field_r(rate_field_r),
	.filter_field_r(filter_field_r), .gain_field_r(gain_field_r), .input_route_field_r(input_route_field_r));

// >>> ams_host_model.sv
// Serial controller model that frames bytes towards the converter.
module ams_host_model (
	input  logic clk,
	input  logic miso_r,
	output logic sclk,
	output logic cs_n,
	output logic mosi
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// Frame engine
	// ----------------------------------------
	// Clock idles low between frames.
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// Edges sit 1 ns after a system edge so the sampled data is never on a race.
	task automatic xfer(input int n, input logic [71:0] tx, output logic [71:0] rx);
		rx = '0;
		@(posedge clk);
		#1 cs_n = 1'b0;
		#24;
		for (int i = 8 * n - 1; i >= 0; i--) begin
			sclk = 1'b1;
			mosi = tx[i];
			#16 sclk = 1'b0;
			rx = {rx[70:0], miso_r};
			#16;
		end
		#16 cs_n = 1'b1;
		mosi = ~mosi;
		#40;
	endtask
endmodule

// >>> tb_ams_converter.sv
// Self-checking bench for the converter driven by the controller model.
module tb_ams_converter;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, resetn, sclk, cs_n, mosi, miso_r, miso_oe_n_r, result_ready_n_r;
	logic        sample_valid, sample_ready_r, feed;
	logic [3:0]  gpio_in, gpio_out_r, gpio_oe_n_r, gain_field_r;
	logic [23:0] sample_data;
	logic [4:0]  rate_field_r;
	logic [2:0]  filter_field_r, input_route_field_r;
	logic [71:0] rx;
	logic [7:0]  r;
	logic [1:0]  ch;
	logic [7:0]  chk_b [4];
	integer      seed = 32'hd951;
	int          miscompares, total_checks, e, q[$];

	ams_converter u_dut (.clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso_r(miso_r),
		.miso_oe_n_r(miso_oe_n_r), .result_ready_n_r(result_ready_n_r), .gpio_in(gpio_in), .gpio_out_r(gpio_out_r),
		.gpio_oe_n_r(gpio_oe_n_r), .sample_valid(sample_valid), .sample_data(sample_data),
		.sample_ready_r(sample_ready_r), .rate_field_r(rate_field_r), .filter_field_r(filter_field_r),
		.gain_field_r(gain_field_r), .input_route_field_r(input_route_field_r));
	ams_host_model u_host (.clk(clk), .miso_r(miso_r), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Register write: the check byte is carried but the converter ignores it.
	task automatic wr(logic [4:0] a, logic [7:0] d, logic [7:0] c);
		u_host.xfer(4, {40'h0, 3'b010, a, d, c, 8'h00}, rx);
	endtask
	task automatic rd();
		u_host.xfer(9, 72'h1200aa000000000000, rx);
		e = q.pop_front();
		chk("lead", rx[71:40], 32'hff1200aa);
		chk("status", rx[39:32] & 8'hfe, 8'h02);
		chk("result", {{8{rx[31]}}, rx[31:8]}, e);
		chk("check", rx[7:0], rx[39:32] ^ rx[31:24] ^ rx[23:16] ^ rx[15:8] ^ 8'h9b);
	endtask
	task automatic wait_ready();
		for (int k = 0; k < 3000 && result_ready_n_r !== 1'b0; k++) @(posedge clk);
		chk("ready", result_ready_n_r, 1'b0);
	endtask
	// Reference queue mirrors every accepted sample, sign-extended as the host stores it.
	always @(posedge clk) begin
		if (sample_valid && sample_ready_r === 1'b1) q.push_back({{8{sample_data[23]}}, sample_data});
		sample_valid <= feed & $random(seed);
		sample_data <= $random(seed);
		gpio_in <= $random(seed);
	end
	// Hang guard, well beyond the expected run.
	initial begin
		#200000;
		miscompares++;
		close_out();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		resetn = 1'b0;
		feed = 1'b0;
		sample_valid = 1'b0;
		sample_data = '0;
		gpio_in = 4'h0;
		chk_b = '{8'h16, 8'h11, 8'h18, 8'h1f};
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		repeat (8) @(posedge clk);
		chk("reset pins", {gpio_oe_n_r, gpio_out_r, sample_ready_r}, 9'h1e0);
		u_host.xfer(4, 72'h0600a900, rx);
		repeat (50) @(posedge clk);
		wr(5'h06, 8'h10, 8'h82);
		for (int i = 0; i < 6; i++) begin
			r = $random(seed);
			wr(5'h02, r, 8'h00);
			wr(5'h04, r, 8'h00);
			wr(5'h10, r, 8'h00);
			chk("rate", {filter_field_r, rate_field_r}, r);
			chk("gain", {input_route_field_r, gain_field_r}, r[6:0]);
			chk("pin drive", gpio_oe_n_r ^ 4'hf, r[3:0] & (r[7:4] ^ 4'hf));
		end
		wr(5'h02, 8'h04, 8'h5a);
		wr(5'h03, 8'h08, 8'h8b);
		wr(5'h04, 8'h87, 8'h9a);
		chk("mode", {gpio_oe_n_r, filter_field_r, rate_field_r}, 12'h804);
		chk("stopped", sample_ready_r, 1'b0);
		feed <= 1'b1;
		for (int c = 0; c < 6; c++) begin
			ch = c[1:0];
			wr(5'h10, {7'h01, ch[1]}, ch[1] ? 8'hd2 : 8'hd5);
			wr(5'h05, {6'h11, ch}, chk_b[ch]);
			chk("steer", {gain_field_r, gpio_out_r}, {3'b001, ch[1], 2'b01, ch});
			u_host.xfer(4, 72'h08007f00, rx);
			wait_ready();
			rd();
		end
		// Stop feeding and drain the holding slot and both buffer entries.
		feed <= 1'b0;
		repeat (4) @(posedge clk);
		for (int k = 0; k < 4 && result_ready_n_r === 1'b0; k++) rd();
		chk("drained", {result_ready_n_r, 8'(q.size())}, 9'h100);
		u_host.xfer(4, 72'h0600a900, rx);
		chk("reset cmd", {sample_ready_r, gpio_oe_n_r, gain_field_r, gpio_out_r}, 13'h0f00);
		close_out();
	end
endmodule
